// file: core/qgc_map.vh
// constants and timing figures for the quasi-resonant gate control core
`ifndef QGC_MAP_VH
`define QGC_MAP_VH

// ----------------------------------------------------------------
// clock and conversion of times to cycles (least times round up)
// ----------------------------------------------------------------
`define QGC_CLK_NS 4
`define QGC_NS_CYC(ns) (((ns) + `QGC_CLK_NS - 1) / `QGC_CLK_NS)
`define QGC_US_CYC(us) `QGC_NS_CYC((us) * 1000)
`define QGC_MS_CYC(ms) `QGC_NS_CYC((ms) * 1000000)

// ----------------------------------------------------------------
// timing figures in their own units
// ----------------------------------------------------------------
`define QGC_SS_SRC_OFF_US 12
`define QGC_SS_STEP_MS 3
`define QGC_SS_TOTAL_MS 24
`define QGC_UDC_TRIG_MS 50
`define QGC_RESTART_US 50
`define QGC_RING_SHORT_US 3
`define QGC_RING_LONG_US 30

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define QGC_CNT_W 24
`define QGC_CNT_ZERO 24'h000000
`define QGC_CNT_ONE 24'h000001
`define QGC_CNT_W_ZC 4
`define QGC_ZC_ZERO 4'h0
`define QGC_ZC_ONE 4'h1
`define QGC_ZC_MAX 4'hf
`define QGC_UDC_LOAD 4'h1
`define QGC_UDC_RST 4'h1
`define QGC_SINK_W 3
`define QGC_SINK_RST 3'h7
`define QGC_SINK_ZERO 3'h0
`define QGC_SINK_ONE 3'h1

// ----------------------------------------------------------------
// comparator input vector bit positions
// ----------------------------------------------------------------
`define QGC_IN_W 7
`define QGC_IN_RST 7'h00
`define QGC_IN_SUPPLY 0
`define QGC_IN_ZC50 1
`define QGC_IN_ZC1V 2
`define QGC_IN_PCSFB 3
`define QGC_IN_FBLO 4
`define QGC_IN_FBHI 5
`define QGC_IN_FBJUMP 6

`endif

// file: core/qgc_sync.v
// two-stage synchroniser for a vector of comparator levels
`timescale 1ns/1ps
`default_nettype none
`include "qgc_map.vh"

module qgc_sync
(
  input wire clk,
  input wire rst_b,
  input wire [`QGC_IN_W-1:0] async_in,
  output reg [`QGC_IN_W-1:0] sync_out
);

  reg [`QGC_IN_W-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_r <= `QGC_IN_RST;
      sync_out <= `QGC_IN_RST;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: core/qgc_timer.v
// loadable down-counter with busy level and expiry pulse
`timescale 1ns/1ps
`default_nettype none
`include "qgc_map.vh"

module qgc_timer
(
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [`QGC_CNT_W-1:0] load_val,
  output wire busy,
  output wire expire
);

  reg [`QGC_CNT_W-1:0] cnt_r;

  // load has priority; count stops at zero
  always @(posedge clk)
  begin
    if (!rst_b)
      cnt_r <= `QGC_CNT_ZERO;
    else if (load)
      cnt_r <= load_val;
    else if (cnt_r != `QGC_CNT_ZERO)
      cnt_r <= cnt_r - `QGC_CNT_ONE;
  end

  assign busy = (cnt_r != `QGC_CNT_ZERO);
  // last counted cycle; a reload in the same cycle cancels it
  assign expire = (cnt_r == `QGC_CNT_ONE) && !load;

endmodule
`default_nettype wire

// file: core/qgc_top.v
// sequencing core of a quasi-resonant flyback gate controller
// Function
// RULE1 - gate held low in start-up mode
// RULE2 - supply above threshold enables reference, soft start
// RULE3 - charge source on, off after 12 us
// RULE4 - sink setting lowered one step every 3 ms
// RULE5 - soft start ends at 24 ms, sink off
// RULE6 - clamp asserted whenever gate is low
// RULE7 - falling zero crossing increments zero-current counter
// RULE8 - gate on when counters equal, unblocked
// RULE9 - zero-cross input above 50 mV forces gate low
// RULE10 - current reaching feedback: gate low, start ringing timer
// RULE11 - no turn-on until ringing timer expires
// RULE12 - ringing time 3 us above 1V, else 30 us
// RULE13 - 4-bit up-down counter of crossings to skip
// RULE14 - 50 ms trigger acts on flags, then clears them
// RULE15 - restart pulse every 50 us when idle low
// RULE16 - zero-current counter cleared at each turn-on
// RULE17 - comparator inputs synchronised, falling edges from samples
`timescale 1ns/1ps
`default_nettype none
`include "qgc_map.vh"

module qgc_top
#(
  parameter [`QGC_CNT_W-1:0] SS_STEP_CYC = `QGC_MS_CYC(`QGC_SS_STEP_MS),
  parameter [`QGC_CNT_W-1:0] SS_TOTAL_CYC = `QGC_MS_CYC(`QGC_SS_TOTAL_MS),
  parameter [`QGC_CNT_W-1:0] UDC_TRIG_CYC = `QGC_MS_CYC(`QGC_UDC_TRIG_MS),
  parameter [`QGC_CNT_W-1:0] RESTART_CYC = `QGC_US_CYC(`QGC_RESTART_US),
  parameter [`QGC_CNT_W-1:0] RING_LONG_CYC = `QGC_US_CYC(`QGC_RING_LONG_US)
)
(
  input wire clk,
  input wire rst_b,
  input wire supply_above_on,
  input wire zc_above_50mv,
  input wire zc_above_1v,
  input wire pcs_at_feedback,
  input wire fb_below_3v5,
  input wire fb_above_4v4,
  input wire fb_above_4v8,
  output reg gate_out,
  output reg pcs_clamp,
  output reg ref_enable,
  output reg ss_source_en,
  output reg ss_sink_en,
  output reg [`QGC_SINK_W-1:0] ss_sink_level,
  output reg softstart_active,
  output reg [`QGC_CNT_W_ZC-1:0] udc_value,
  output reg [`QGC_CNT_W_ZC-1:0] zcc_value
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [2:0] ST_STARTUP = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;
  localparam [`QGC_CNT_W-1:0] SS_SRC_OFF_CYC = `QGC_US_CYC(`QGC_SS_SRC_OFF_US);
  localparam [`QGC_CNT_W-1:0] RING_SHORT_CYC = `QGC_US_CYC(`QGC_RING_SHORT_US);

  // saturating step of a 4-bit counter, up or down
  function [`QGC_CNT_W_ZC-1:0] sat_step;
    input [`QGC_CNT_W_ZC-1:0] val;
    input up;
    begin
      if (up)
        sat_step = (val == `QGC_ZC_MAX) ? val : val + `QGC_ZC_ONE;
      else
        sat_step = (val == `QGC_ZC_ZERO) ? val : val - `QGC_ZC_ONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  wire [`QGC_IN_W-1:0] raw_in;
  wire [`QGC_IN_W-1:0] syn_in;
  reg zc50_prev_r;

  assign raw_in = {fb_above_4v8, fb_above_4v4, fb_below_3v5, pcs_at_feedback,
                   zc_above_1v, zc_above_50mv, supply_above_on};

  qgc_sync u_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(raw_in), // RULE17
    .sync_out(syn_in)
  );

  wire supply_ok = syn_in[`QGC_IN_SUPPLY];
  wire zc_hi = syn_in[`QGC_IN_ZC50];
  wire zc_over_1v = syn_in[`QGC_IN_ZC1V];
  wire pcs_hit = syn_in[`QGC_IN_PCSFB];
  wire fb_lo = syn_in[`QGC_IN_FBLO];
  wire fb_hi = syn_in[`QGC_IN_FBHI];
  wire fb_jump = syn_in[`QGC_IN_FBJUMP];

  // falling edge taken from the second stage, never the first
  always @(posedge clk)
  begin
    if (!rst_b)
      zc50_prev_r <= 1'b0;
    else
      zc50_prev_r <= zc_hi;
  end

  wire zc_fall = zc50_prev_r && !zc_hi; // RULE17

  // ----------------------------------------------------------------
  // start-up and soft-start sequencing
  // ----------------------------------------------------------------
  reg [2:0] state_r;
  reg [`QGC_CNT_W-1:0] ss_cnt_r;
  reg [`QGC_CNT_W-1:0] step_cnt_r;

  // reset is only released while the part sits in start-up mode
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= ST_STARTUP;
      ref_enable <= 1'b0;
      ss_source_en <= 1'b0;
      ss_sink_en <= 1'b0;
      ss_sink_level <= `QGC_SINK_RST;
      softstart_active <= 1'b0;
      ss_cnt_r <= `QGC_CNT_ZERO;
      step_cnt_r <= `QGC_CNT_ZERO;
    end
    else
    begin
      case (state_r)
        ST_STARTUP:
        begin
          if (supply_ok)
          begin
            state_r <= ST_SOFT; // RULE2
            ref_enable <= 1'b1; // RULE2
            softstart_active <= 1'b1;
            ss_source_en <= 1'b1; // RULE3
            ss_sink_en <= 1'b1;
            ss_sink_level <= `QGC_SINK_RST;
            ss_cnt_r <= `QGC_CNT_ZERO;
            step_cnt_r <= `QGC_CNT_ZERO;
          end
        end
        ST_SOFT:
        begin
          ss_cnt_r <= ss_cnt_r + `QGC_CNT_ONE;
          // charge source only for the first few microseconds
          if (ss_cnt_r == SS_SRC_OFF_CYC - `QGC_CNT_ONE)
            ss_source_en <= 1'b0; // RULE3
          // sink weakens in steps so the feedback node climbs gradually
          if (step_cnt_r == SS_STEP_CYC - `QGC_CNT_ONE)
          begin
            step_cnt_r <= `QGC_CNT_ZERO;
            if (ss_sink_level != `QGC_SINK_ZERO)
              ss_sink_level <= ss_sink_level - `QGC_SINK_ONE; // RULE4
          end
          else
            step_cnt_r <= step_cnt_r + `QGC_CNT_ONE;
          if (ss_cnt_r == SS_TOTAL_CYC - `QGC_CNT_ONE)
          begin
            state_r <= ST_RUN; // RULE5
            softstart_active <= 1'b0;
            ss_sink_en <= 1'b0; // RULE5
            ss_sink_level <= `QGC_SINK_ZERO;
            ss_source_en <= 1'b0;
          end
        end
        ST_RUN:
          state_r <= ST_RUN;
        default:
        begin
          state_r <= ST_STARTUP;
          ref_enable <= 1'b0;
          softstart_active <= 1'b0;
          ss_source_en <= 1'b0;
          ss_sink_en <= 1'b0;
        end
      endcase
    end
  end

  wire active = (state_r == ST_SOFT) || (state_r == ST_RUN);

  // ----------------------------------------------------------------
  // frequency-reduction up-down counter
  // ----------------------------------------------------------------
  reg [`QGC_CNT_W-1:0] trig_cnt_r;
  reg flag_lo_r;
  reg flag_hi_r;
  reg flag_jump_r;
  wire trig = active && (trig_cnt_r == UDC_TRIG_CYC - `QGC_CNT_ONE);

  // periodic trigger, free running once the reference is up
  always @(posedge clk)
  begin
    if (!rst_b || !active || trig)
      trig_cnt_r <= `QGC_CNT_ZERO;
    else
      trig_cnt_r <= trig_cnt_r + `QGC_CNT_ONE;
  end

  // range flags: a sample in the trigger cycle survives the clear
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      flag_lo_r <= 1'b0;
      flag_hi_r <= 1'b0;
      flag_jump_r <= 1'b0;
    end
    else if (trig)
    begin
      flag_lo_r <= fb_lo; // RULE14
      flag_hi_r <= fb_hi;
      flag_jump_r <= fb_jump;
    end
    else if (active)
    begin
      flag_lo_r <= flag_lo_r | fb_lo;
      flag_hi_r <= flag_hi_r | fb_hi;
      flag_jump_r <= flag_jump_r | fb_jump;
    end
  end

  // load beats decrement beats increment
  always @(posedge clk)
  begin
    if (!rst_b)
      udc_value <= `QGC_UDC_RST; // RULE13
    else if (trig)
    begin
      if (flag_jump_r)
        udc_value <= `QGC_UDC_LOAD; // RULE14
      else if (flag_hi_r)
        udc_value <= sat_step(udc_value, 1'b0); // RULE14
      else if (flag_lo_r)
        udc_value <= sat_step(udc_value, 1'b1); // RULE14
    end
  end

  // ----------------------------------------------------------------
  // ringing suppression and restart timers
  // ----------------------------------------------------------------
  reg gate_nxt;
  wire turn_off_pcs = gate_out && pcs_hit;
  wire ring_busy;
  wire restart_busy;
  wire restart_fire;
  wire idle_low = active && !zc_hi && !gate_out;

  qgc_timer u_ring
  (
    .clk(clk),
    .rst_b(rst_b),
    .load(turn_off_pcs), // RULE10
    .load_val(zc_over_1v ? RING_SHORT_CYC : RING_LONG_CYC), // RULE12
    .busy(ring_busy),
    .expire()
  );

  // reload when idle ends or the count runs out, giving an exact period
  qgc_timer u_restart
  (
    .clk(clk),
    .rst_b(rst_b),
    .load(!idle_low || !restart_busy),
    .load_val(RESTART_CYC - `QGC_CNT_ONE),
    .busy(restart_busy),
    .expire(restart_fire) // RULE15
  );

  // ----------------------------------------------------------------
  // zero-current counter and gate decision
  // ----------------------------------------------------------------
  wire zc_match = (zcc_value == udc_value); // RULE8
  wire blocked = !active || zc_hi || ring_busy; // RULE11

  // turn-off causes win over any turn-on in the same cycle
  always @*
  begin
    gate_nxt = gate_out;
    if (!active)
      gate_nxt = 1'b0; // RULE1
    else if (zc_hi)
      gate_nxt = 1'b0; // RULE9
    else if (turn_off_pcs)
      gate_nxt = 1'b0; // RULE10
    else if (!gate_out && !blocked && (zc_match || restart_fire))
      gate_nxt = 1'b1; // RULE8
  end

  // counter restarts with each switching period
  always @(posedge clk)
  begin
    if (!rst_b)
      zcc_value <= `QGC_ZC_ZERO;
    else if (gate_nxt && !gate_out)
      zcc_value <= `QGC_ZC_ZERO; // RULE16
    else if (zc_fall && !gate_out)
      zcc_value <= sat_step(zcc_value, 1'b1); // RULE7
  end

  // clamp follows the gate so the simulation node never floats
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      gate_out <= 1'b0; // RULE1
      pcs_clamp <= 1'b1;
    end
    else
    begin
      gate_out <= gate_nxt;
      pcs_clamp <= !gate_nxt; // RULE6
    end
  end

endmodule
`default_nettype wire

// file: testbench/qgc_checker.sv
// assertions on the gate control core ports
`timescale 1ns/1ps
`default_nettype none
`include "qgc_map.vh"
module qgc_checker
#(
  parameter [`QGC_CNT_W-1:0] RING_LONG_CYC = 24'h001d4c
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic supply_above_on,
  input wire logic zc_above_50mv,
  input wire logic pcs_at_feedback,
  input wire logic gate_out,
  input wire logic pcs_clamp,
  input wire logic ref_enable,
  input wire logic ss_source_en,
  input wire logic ss_sink_en,
  input wire logic [`QGC_SINK_W-1:0] ss_sink_level,
  input wire logic softstart_active,
  input wire logic [`QGC_CNT_W_ZC-1:0] zcc_value
);
  logic [`QGC_CNT_W-1:0] low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // low time of the gate, saturating so a long idle cannot wrap
  always_ff @(posedge clk)
  begin
    if (!rst_b || gate_out)
      low_cnt <= `QGC_CNT_ZERO;
    else if (low_cnt != 24'hffffff)
      low_cnt <= low_cnt + `QGC_CNT_ONE;
  end
  // --------------------------------
  // soft start sequence
  // --------------------------------
  sequence s_seen; $rose(supply_above_on) && !ref_enable; endsequence
  sequence s_on; ##3 ref_enable && softstart_active && ss_source_en && ss_sink_en; endsequence
  property p_start; !ref_enable |-> !gate_out; endproperty
  a_start: assert property (p_start) else $error("gate on in start-up");
  property p_entry; s_seen |-> s_on; endproperty
  a_entry: assert property (p_entry) else $error("soft start entry late");
  property p_sink; $changed(ss_sink_level) && softstart_active |->
    ss_sink_level == $past(ss_sink_level) - 3'h1; endproperty
  a_sink: assert property (p_sink) else $error("sink step wrong");
  property p_end; $fell(softstart_active) |-> !ss_sink_en && ss_sink_level == 3'h0; endproperty
  a_end: assert property (p_end) else $error("sink left on");
  // --------------------------------
  // switching
  // --------------------------------
  property p_clamp; pcs_clamp == !gate_out; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp wrong");
  property p_zcc; $changed(zcc_value) && zcc_value != 4'h0 |->
    zcc_value == $past(zcc_value) + 4'h1 && !gate_out; endproperty
  a_zcc: assert property (p_zcc) else $error("count step wrong");
  property p_zc; zc_above_50mv |-> ##3 !gate_out; endproperty
  a_zc: assert property (p_zc) else $error("gate on above 50 mV");
  property p_pcs; pcs_at_feedback && gate_out |-> ##[1:3] !gate_out; endproperty
  a_pcs: assert property (p_pcs) else $error("gate not cut");
  property p_ring; $rose(gate_out) |-> low_cnt >= RING_LONG_CYC - 24'h000002; endproperty
  a_ring: assert property (p_ring) else $error("ring time cut short");
  property p_clr; $rose(gate_out) |-> zcc_value == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");
endmodule
bind qgc_top qgc_checker #(.RING_LONG_CYC(RING_LONG_CYC)) chk_u (.clk(clk), .rst_b(rst_b),
  .supply_above_on(supply_above_on), .zc_above_50mv(zc_above_50mv),
  .pcs_at_feedback(pcs_at_feedback), .gate_out(gate_out), .pcs_clamp(pcs_clamp),
  .ref_enable(ref_enable), .ss_source_en(ss_source_en), .ss_sink_en(ss_sink_en),
  .ss_sink_level(ss_sink_level), .softstart_active(softstart_active), .zcc_value(zcc_value));
`default_nettype wire

// file: testbench/qgc_partner.sv
// behavioural flyback stage and comparator front end
`timescale 1ns/1ps
`default_nettype none
module qgc_partner
(
  input wire logic clk,
  input wire logic gate_out,
  input wire logic force_zc,
  input wire logic [3:0] n_ring,
  output logic zc_above_50mv,
  output logic pcs_at_feedback
);
  logic g_r;
  logic [9:0] t_r;
  logic [9:0] ring_end;
  assign ring_end = 10'h01e + 10'h014 * {6'h00, n_ring};
  initial
  begin
    g_r = 1'b0;
    t_r = 10'h3ff;
    zc_above_50mv = 1'b0;
    pcs_at_feedback = 1'b0;
  end
  // demag for 30 cycles, then n_ring more crossings; ramp trips 20 cycles into on-time
  always @(negedge clk)
  begin
    g_r <= gate_out;
    t_r <= (gate_out != g_r) ? 10'h000 : t_r + {9'h000, t_r != 10'h3ff};
    zc_above_50mv <= force_zc || (!g_r && (t_r < 10'h01e ||
      (t_r < ring_end && t_r % 10'h014 < 10'h00a)));
    pcs_at_feedback <= g_r && t_r > 10'h014;
  end
endmodule
`default_nettype wire

// file: testbench/qgc_top_bench.sv
// self-checking bench for the gate control core
`timescale 1ns/1ps
`default_nettype none
module qgc_top_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_above_on = 1'b0;
  logic zc_above_1v = 1'b0;
  logic force_zc = 1'b0;
  logic [3:0] n_ring = 4'h0;
  logic [2:0] fb = 3'h0;
  wire zc_above_50mv, pcs_at_feedback, gate_out, pcs_clamp, ref_enable;
  wire ss_source_en, ss_sink_en, softstart_active;
  wire [2:0] ss_sink_level;
  wire [3:0] udc_value, zcc_value;
  int err_count = 0;
  int comparisons = 0;
  int el = 0;
  int hi_t, lo_t;
  // 250 MHz clock
  always #2 clk = ~clk;
  // short counts keep the run small: step 380, total 3040, trigger 200, restart 100, ring 40
  // soft start must outlast the fixed 3000-cycle source time, or the source cut goes untested
  qgc_top #(.SS_STEP_CYC(24'h00017c), .SS_TOTAL_CYC(24'h000be0), .UDC_TRIG_CYC(24'h0000c8),
    .RESTART_CYC(24'h000064), .RING_LONG_CYC(24'h000028)) dut_u (.clk(clk), .rst_b(rst_b),
    .supply_above_on(supply_above_on), .zc_above_50mv(zc_above_50mv),
    .zc_above_1v(zc_above_1v), .pcs_at_feedback(pcs_at_feedback), .fb_below_3v5(fb[0]),
    .fb_above_4v4(fb[1]), .fb_above_4v8(fb[2]), .gate_out(gate_out), .pcs_clamp(pcs_clamp),
    .ref_enable(ref_enable), .ss_source_en(ss_source_en), .ss_sink_en(ss_sink_en),
    .ss_sink_level(ss_sink_level), .softstart_active(softstart_active),
    .udc_value(udc_value), .zcc_value(zcc_value));
  qgc_partner pm_u (.clk(clk), .gate_out(gate_out), .force_zc(force_zc), .n_ring(n_ring),
    .zc_above_50mv(zc_above_50mv), .pcs_at_feedback(pcs_at_feedback));
  // --------------------------------
  // shared helpers
  // --------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one sampled cycle; a hang past 2000 cycles ends the run
  task automatic step(inout int c);
    @(posedge clk);
    #1;
    c++;
    if (c > 2000)
    begin
      err_count++;
      final_report();
    end
  endtask
  task automatic go(input int k);
    repeat (k - el) @(posedge clk);
    el = k;
    #1;
  endtask
  task automatic wait_gate(input logic lvl, output int n);
    n = 0;
    while (gate_out !== lvl)
      step(n);
  endtask
  task automatic period;
    wait_gate(1'b1, lo_t);
    wait_gate(1'b0, hi_t);
    wait_gate(1'b1, lo_t);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(negedge clk);
    fb = v;
    @(negedge clk);
    fb = 3'h0;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    repeat (20) @(negedge clk);
    chk("clamp", 4'h1, pcs_clamp);
    chk("udc", 4'h1, udc_value);
    chk("sink", 4'h7, ss_sink_level);
    rst_b = 1'b1;
    repeat (60) @(negedge clk);
    chk("ref", 4'h0, ref_enable);
    chk("gate", 4'h0, gate_out);
    $display("test reset done");
  endtask
  task automatic t_soft;
    int n;
    n = 0;
    supply_above_on = 1'b1;
    while (ref_enable !== 1'b1)
      step(n);
    chk("entry", 4'h3, n[3:0]);
    chk("active", 4'h1, {softstart_active, ss_source_en, ss_sink_en} == 3'h7);
    go(200);
    chk("sink", 4'h7, ss_sink_level);
    go(400);
    chk("sink", 4'h6, ss_sink_level);
    go(1200);
    chk("sink", 4'h4, ss_sink_level);
    go(2990);
    chk("sink", 4'h0, ss_sink_level);
    chk("source", 4'h1, ss_source_en);
    go(3010);
    chk("source", 4'h0, ss_source_en);
    chk("active", 4'h1, softstart_active);
    go(3050);
    chk("end", 4'h0, {softstart_active, ss_sink_en} != 2'h0);
    chk("udc", 4'h1, udc_value);
    $display("test soft start done");
  endtask
  task automatic t_udc;
    pulse(3'h1);
    go(3300);
    chk("udc", 4'h2, udc_value);
    pulse(3'h1);
    go(3500);
    chk("udc", 4'h3, udc_value);
    pulse(3'h2);
    go(3700);
    chk("udc", 4'h2, udc_value);
    go(3750);
    pulse(3'h6);
    go(3790);
    chk("udc", 4'h2, udc_value);
    go(3900);
    chk("udc", 4'h1, udc_value);
    pulse(3'h1);
    pulse(3'h1);
    go(4300);
    chk("udc", 4'h2, udc_value);
    pulse(3'h1);
    go(4500);
    chk("udc", 4'h3, udc_value);
    $display("test up-down counter done");
  endtask
  task automatic t_count;
    int f;
    int c;
    logic z;
    f = 0;
    c = 0;
    @(negedge clk);
    n_ring = 4'h4;
    wait_gate(1'b1, hi_t);
    wait_gate(1'b0, hi_t);
    z = zc_above_50mv;
    while (gate_out !== 1'b1)
    begin
      step(c);
      if (z && !zc_above_50mv)
        f++;
      z = zc_above_50mv;
    end
    chk("falls", 4'h3, f[3:0]);
    chk("zcc", 4'h0, zcc_value);
    $display("test zero crossing done");
  endtask
  task automatic t_ring;
    @(negedge clk);
    n_ring = 4'h0;
    period();
    period();
    chk("on", 4'h1, hi_t >= 20 && hi_t <= 30);
    chk("restart", 4'h1, lo_t >= 120 && lo_t <= 150);
    @(negedge clk);
    zc_above_1v = 1'b1;
    period();
    period();
    chk("ring", 4'h1, lo_t >= 748 && lo_t <= 900);
    @(negedge clk);
    zc_above_1v = 1'b0;
    $display("test ringing done");
  endtask
  task automatic t_force;
    int f;
    f = 0;
    @(negedge clk);
    force_zc = 1'b1;
    repeat (8) @(posedge clk);
    repeat (300)
    begin
      @(posedge clk);
      #1;
      if (gate_out !== 1'b0)
        f++;
    end
    chk("forced", 4'h0, {3'h0, f != 0});
    @(negedge clk);
    force_zc = 1'b0;
    wait_gate(1'b1, f);
    chk("resume", 4'h1, {3'h0, f >= 95 && f <= 110});
    $display("test forced low done");
  endtask
  // main sequence
  initial
  begin
    t_reset();
    t_soft();
    t_udc();
    t_count();
    t_ring();
    t_force();
    final_report();
  end
endmodule
`default_nettype wire
